// ---- common/pcif_pkg.sv ----
// ----------------------------------------------------------------------------
// Pin-change interrupt flags: shared constants and types
// ----------------------------------------------------------------------------
package pcif_pkg;

  // Port geometry: index 0 = A, 1 = B, 2 = C, 3 = E
  localparam int unsigned NPORT     = 4;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned PORT_E    = 3;
  localparam int unsigned PORT_SHIFT = 4;          // Each port owns a 16-byte block

  // Register offsets inside a port block (byte addresses)
  localparam logic [31:0] OFS_RISE  = 32'h0000_0000;
  localparam logic [31:0] OFS_FALL  = 32'h0000_0004;
  localparam logic [31:0] OFS_FLAG  = 32'h0000_0008;

  // Global control and status register
  localparam logic [31:0] OFS_CTRL  = 32'h0000_0040;
  localparam int unsigned CTRL_GIE_BIT = 0;        // Global change-interrupt enable, RW
  localparam int unsigned CTRL_SUM_BIT = 1;        // Summary change flag, RO
  localparam int unsigned CTRL_SLP_BIT = 2;        // Core sleep level as seen by the block, RO

  // Pin layout and implemented bits per port
  typedef logic [NPORT-1:0][PORT_W-1:0] pcif_pins_t;
  localparam pcif_pins_t RISE_MASK = {8'h08, 8'hff, 8'hff, 8'hff};
  localparam pcif_pins_t FALL_MASK = {8'h00, 8'hff, 8'hff, 8'hff};
  localparam pcif_pins_t FLAG_MASK = {8'h08, 8'hff, 8'hff, 8'hff};
  localparam pcif_pins_t PINS_RST  = '0;

  // Event outputs toward the processor core
  typedef struct packed {
    logic irq;                                     // Change interrupt request
    logic wake;                                    // Wake from Sleep
    logic summary;                                 // OR of all pin flags
  } pcif_evt_t;
  localparam pcif_evt_t EVT_RST = '0;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

endpackage

// ---- core/pcif_edge_det.sv ----
// ----------------------------------------------------------------------------
// Two-stage pin synchroniser with rising and falling edge detection
// ----------------------------------------------------------------------------
module pcif_edge_det (
  input  wire logic               clk_i,   // System clock
  input  wire logic               srst_i,  // Synchronous reset, active high
  input  wire pcif_pkg::pcif_pins_t pins_i,  // Raw pins, asynchronous
  output      pcif_pkg::pcif_pins_t rise_o,  // One-cycle rising edge pulses
  output      pcif_pkg::pcif_pins_t fall_o   // One-cycle falling edge pulses
);

  pcif_pkg::pcif_pins_t sync1_q;
  pcif_pkg::pcif_pins_t sync2_q;
  pcif_pkg::pcif_pins_t prev_q;
  logic [2:0]           primed_q;              // Start-up guard until prev_q holds a real pin sample

  // Synchroniser, previous sample and start-up guard
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_q  <= pcif_pkg::PINS_RST;
      sync2_q  <= pcif_pkg::PINS_RST;
      prev_q   <= pcif_pkg::PINS_RST;
      primed_q <= 3'h0;
    end else begin
      sync1_q  <= pins_i;
      sync2_q  <= sync1_q;
      prev_q   <= sync2_q;
      primed_q <= {primed_q[1:0], 1'b1};
    end
  end

  // Compare current and previous synchronised samples
  // Guard holds until both pipeline stages carry real pin levels, so a pin high at reset is no edge
  assign rise_o = primed_q[2] ? (sync2_q & ~prev_q) : pcif_pkg::PINS_RST;
  assign fall_o = primed_q[2] ? (~sync2_q & prev_q) : pcif_pkg::PINS_RST;

endmodule

// ---- core/pcif_top.sv ----
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
module pcif_top (
  input  wire logic                 clk_i,        // System clock, 25 MHz
  input  wire logic                 srst_i,       // Synchronous reset, active high
  // AHB-Lite slave
  input  wire logic                 hsel_i,       // Slave select
  input  wire logic [31:0]          haddr_i,      // Byte address
  input  wire logic [1:0]           htrans_i,     // Transfer type
  input  wire logic                 hwrite_i,     // Write when high
  input  wire logic [2:0]           hsize_i,      // Transfer size, word only
  input  wire logic                 hready_i,     // Bus ready
  input  wire logic [31:0]          hwdata_i,     // Write data
  output      logic [31:0]          hrdata_o,     // Read data
  output      logic                 hreadyout_o,  // Slave ready
  output      logic                 hresp_o,      // Response, always OKAY
  // Pins and core
  input  wire pcif_pkg::pcif_pins_t pins_i,       // Port pins E, C, B, A
  input  wire logic                 sleep_i,      // Core is in Sleep
  output      pcif_pkg::pcif_evt_t  evt_o         // Interrupt, wake and summary
);

  // --------------------------------------------------------------------------
  // Address decode helpers
  // --------------------------------------------------------------------------

  // Byte address of a register in a given port block
  function automatic logic [31:0] port_addr(input int unsigned port, input logic [31:0] ofs);
    logic [31:0] base;
    base = 32'(port) << pcif_pkg::PORT_SHIFT;
    return base + ofs;
  endfunction

  // True when an address selects the given register of the given port
  function automatic logic hits(input logic [31:0] addr, input int unsigned port,
                                input logic [31:0] ofs);
    return addr == port_addr(port, ofs);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------

  pcif_pkg::pcif_pins_t rise_q;                    // Rising-edge enables
  pcif_pkg::pcif_pins_t fall_q;                    // Falling-edge enables
  pcif_pkg::pcif_pins_t flag_q;                    // Pin change flags
  pcif_pkg::pcif_pins_t rise_d;
  pcif_pkg::pcif_pins_t fall_d;
  pcif_pkg::pcif_pins_t flag_d;
  logic                 gie_q;                     // Global change-interrupt enable
  logic                 gie_d;

  logic                 dp_valid_q;                // Data phase of a taken transfer
  logic                 dp_write_q;
  logic [31:0]          dp_addr_q;

  logic [31:0]          hrdata_q;
  logic [31:0]          rdata_d;
  logic                 hready_q;
  logic                 hresp_q;
  pcif_pkg::pcif_evt_t  evt_q;

  pcif_pkg::pcif_pins_t pin_rise;                  // Synchronised edge pulses
  pcif_pkg::pcif_pins_t pin_fall;
  pcif_pkg::pcif_pins_t pin_set;                   // Hardware set requests

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------

  // Synchroniser and edge detector for all pins
  pcif_edge_det u_edge (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .pins_i (pins_i),
    .rise_o (pin_rise),
    .fall_o (pin_fall)
  );

  // Flag set requests from enabled edges, either or both directions
  assign pin_set = (pin_rise & rise_q) | (pin_fall & fall_q);

  // --------------------------------------------------------------------------
  // AHB-Lite transfer tracking
  // --------------------------------------------------------------------------

  logic addr_take;
  logic wr_en;
  logic wr_ctrl;

  // Address phase accepted when selected, active and the bus is ready
  assign addr_take = hsel_i & hready_i & (htrans_i == pcif_pkg::HTRANS_NONSEQ
                                          || htrans_i == (pcif_pkg::HTRANS_NONSEQ | 2'h1));
  assign wr_en     = dp_valid_q & dp_write_q;
  assign wr_ctrl   = wr_en & (dp_addr_q == pcif_pkg::OFS_CTRL);

  // Capture address phase for use in the data phase
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= '0;
    end else begin
      dp_valid_q <= addr_take;
      dp_write_q <= hwrite_i;
      dp_addr_q  <= haddr_i;
    end
  end

  // --------------------------------------------------------------------------
  // Register next values, one generate slice per port
  // --------------------------------------------------------------------------

  logic [pcif_pkg::NPORT-1:0] wr_rise;
  logic [pcif_pkg::NPORT-1:0] wr_fall;
  logic [pcif_pkg::NPORT-1:0] wr_flag;

  for (genvar p = 0; p < pcif_pkg::NPORT; p++) begin : g_port
    // Write strobes of this port's registers
    assign wr_rise[p] = wr_en & hits(dp_addr_q, p, pcif_pkg::OFS_RISE);
    assign wr_fall[p] = wr_en & hits(dp_addr_q, p, pcif_pkg::OFS_FALL);
    assign wr_flag[p] = wr_en & hits(dp_addr_q, p, pcif_pkg::OFS_FLAG);

    // Enables keep only implemented bits
    assign rise_d[p] = (wr_rise[p] ? hwdata_i[7:0] : rise_q[p])
                       & pcif_pkg::RISE_MASK[p];
    assign fall_d[p] = (wr_fall[p] ? hwdata_i[7:0] : fall_q[p])
                       & pcif_pkg::FALL_MASK[p];

    // Written value first, then hardware set wins over any written zero
    assign flag_d[p] = ((wr_flag[p] ? hwdata_i[7:0] : flag_q[p])
                       | pin_set[p])
                       & pcif_pkg::FLAG_MASK[p];
  end

  assign gie_d = wr_ctrl ? hwdata_i[pcif_pkg::CTRL_GIE_BIT] : gie_q;

  // Register file, all cleared on any reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rise_q <= pcif_pkg::PINS_RST;
      fall_q <= pcif_pkg::PINS_RST;
      flag_q <= pcif_pkg::PINS_RST;
      gie_q  <= 1'b0;
    end else begin
      rise_q <= rise_d;
      fall_q <= fall_d;
      flag_q <= flag_d;
      gie_q  <= gie_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------

  logic summary_now;
  logic summary_nxt;

  // Summary of all flags, current and after this cycle's update
  assign summary_now = |flag_q;
  assign summary_nxt = |flag_d;

  // Read mux on the values the registers will hold after any write in flight
  always_comb begin
    rdata_d = '0;
    for (int unsigned p = 0; p < pcif_pkg::NPORT; p++) begin
      if (hits(haddr_i, p, pcif_pkg::OFS_RISE)) begin
        rdata_d[7:0] = rise_d[p];
      end
      if (hits(haddr_i, p, pcif_pkg::OFS_FALL)) begin
        rdata_d[7:0] = fall_d[p];
      end
      if (hits(haddr_i, p, pcif_pkg::OFS_FLAG)) begin
        rdata_d[7:0] = flag_d[p];
      end
    end
    if (haddr_i == pcif_pkg::OFS_CTRL) begin
      rdata_d[pcif_pkg::CTRL_GIE_BIT] = gie_d;
      rdata_d[pcif_pkg::CTRL_SUM_BIT] = summary_nxt;
      rdata_d[pcif_pkg::CTRL_SLP_BIT] = sleep_i;
    end
  end

  // Bus answer registers: zero wait states, always OKAY
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hrdata_q <= pcif_pkg::RDATA_RST;
      hready_q <= 1'b1;
      hresp_q  <= pcif_pkg::HRESP_OKAY;
    end else begin
      hrdata_q <= (addr_take & ~hwrite_i) ? rdata_d : pcif_pkg::RDATA_RST;
      hready_q <= 1'b1;
      hresp_q  <= pcif_pkg::HRESP_OKAY;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt and wake
  // --------------------------------------------------------------------------

  // Request and wake gated by the global enable; flags keep running without it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      evt_q <= pcif_pkg::EVT_RST;
    end else begin
      evt_q.irq     <= gie_q & summary_now;
      evt_q.wake    <= gie_q & summary_now & sleep_i;
      evt_q.summary <= summary_now;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  assign hrdata_o    = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o     = hresp_q;
  assign evt_o       = evt_q;

endmodule

// ---- dv/pcif_top_assertions.sv ----
module pcif_top_assertions (
  input wire logic                 clk_i,        // System clock
  input wire logic                 srst_i,       // Synchronous reset
  input wire logic                 hsel_i,       // Slave select
  input wire logic [31:0]          haddr_i,      // Byte address
  input wire logic [1:0]           htrans_i,     // Transfer type
  input wire logic                 hwrite_i,     // Write when high
  input wire logic [2:0]           hsize_i,      // Transfer size
  input wire logic                 hready_i,     // Bus ready
  input wire logic [31:0]          hwdata_i,     // Write data
  input wire logic [31:0]          hrdata_o,     // Read data
  input wire logic                 hreadyout_o,  // Slave ready
  input wire logic                 hresp_o,      // Response
  input wire pcif_pkg::pcif_pins_t pins_i,       // Port pins
  input wire logic                 sleep_i,      // Core in Sleep
  input wire pcif_pkg::pcif_evt_t  evt_o         // Events
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // Transfers taken by the slave
  // ----------------------------------------
  wire take_w = hsel_i & hready_i & htrans_i[1];
  wire rd_take = take_w & ~hwrite_i;
  wire wr_take = take_w & hwrite_i;
  reset_values_a: assert property (disable iff (1'b0) srst_i |=>
    evt_o === pcif_pkg::EVT_RST && hrdata_o === pcif_pkg::RDATA_RST) else $error("outputs not cleared by reset");
  bus_okay_a: assert property (hreadyout_o && hresp_o == pcif_pkg::HRESP_OKAY) else $error("bus not ready or not okay");
  irq_needs_flag_a: assert property (evt_o.irq |-> evt_o.summary) else $error("request without a flag");
  wake_needs_irq_a: assert property (evt_o.wake |-> evt_o.irq) else $error("wake without request");
  wake_needs_sleep_a: assert property (evt_o.wake |-> $past(sleep_i)) else $error("wake outside sleep");
  flag_clear_cause_a: assert property ($fell(evt_o.summary) |->
    $past(wr_take, 2) || $past(wr_take, 3) || $past(wr_take, 4)) else $error("summary fell without a write");
  porte_bits_a: assert property (rd_take && haddr_i == 32'h0000_0030 |=>
    hrdata_o[31:4] == 28'h0 && hrdata_o[2:0] == 3'h0) else $error("port e enable has extra bits");
  enable_width_a: assert property (rd_take && haddr_i[31:6] == 26'h0 |=>
    hrdata_o[31:8] == 24'h0) else $error("port register wider than a byte");
  cover property (evt_o.wake);
  cover property (evt_o.irq);
  cover property ($fell(evt_o.summary));
endmodule

bind pcif_top pcif_top_assertions u_chk (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pins_i(pins_i), .sleep_i(sleep_i),
  .evt_o(evt_o));

// ---- dv/pcif_pin_model.sv ----
module pcif_pin_model (
  input  wire logic                 clk_i,   // System clock
  output      pcif_pkg::pcif_pins_t pins_o,  // Pin levels
  output      logic                 sleep_o  // Core Sleep level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins idle low, core awake
  initial begin
    pins_o = '0;
    sleep_o = 1'b0;
  end
  // A level change lands after an edge and holds two clocks so it is seen
  task automatic set_pin(input int p, input int b, input logic v);
    pins_o[p][b] <= v;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic set_sleep(input logic v);
    sleep_o <= v;
  endtask
endmodule

// ---- dv/pin_change_interrupt_flags_tb_top.sv ----
module pin_change_interrupt_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, sleep;
  pcif_pkg::pcif_pins_t pins;
  pcif_pkg::pcif_evt_t evt;
  int n_errors = 0, samples_checked = 0;
  always #20 clk = ~clk;
  pcif_pin_model u_pins (.clk_i(clk), .pins_o(pins), .sleep_o(sleep));
  pcif_top u_dut (.clk_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hreadyout), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .pins_i(pins), .sleep_i(sleep), .evt_o(evt));
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    haddr <= a; htrans <= pcif_pkg::HTRANS_NONSEQ; hwrite <= wr; hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, '0, q);
    check(name, q, exp);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int p = 0; p < 4; p++)
      for (int r = 0; r < 3; r++) rd_chk("reset value", 32'(16 * p + 4 * r), '0);
    rd_chk("reset ctrl", pcif_pkg::OFS_CTRL, '0);
  endtask
  task automatic t_widths();
    wr(32'h0000_0000, 32'hffff_ffff); wr(32'h0000_0004, 32'hffff_ffff); wr(32'h0000_0030, 32'hffff_ffff);
    rd_chk("a rise enable", 32'h0000_0000, 32'h0000_00ff);
    rd_chk("a fall enable", 32'h0000_0004, 32'h0000_00ff);
    rd_chk("e rise enable", 32'h0000_0030, 32'h0000_0008);
    rd_chk("unmapped", 32'h0000_0050, '0);
    wr(32'h0000_0000, 32'h0000_0001); wr(32'h0000_0004, 32'h0000_0002);
  endtask
  task automatic t_edges();
    wr(32'h0000_0010, 32'h0000_0080); wr(32'h0000_0014, 32'h0000_0080); wr(32'h0000_0020, 32'h0000_0008);
    u_pins.set_pin(0, 0, 1'b1); u_pins.set_pin(0, 1, 1'b1); u_pins.set_pin(1, 7, 1'b1); u_pins.set_pin(3, 3, 1'b1);
    repeat (6) @(posedge clk);
    rd_chk("a flags rise", 32'h0000_0008, 32'h0000_0001);
    rd_chk("e flags rise", 32'h0000_0038, 32'h0000_0008);
    wr(32'h0000_0018, 32'h0000_0000);
    rd_chk("b flags cleared", 32'h0000_0018, '0);
    u_pins.set_pin(0, 0, 1'b0); u_pins.set_pin(0, 1, 1'b0); u_pins.set_pin(1, 7, 1'b0);
    repeat (6) @(posedge clk);
    rd_chk("a flags fall", 32'h0000_0008, 32'h0000_0003);
    rd_chk("b flags fall", 32'h0000_0018, 32'h0000_0080);
    check("summary", 32'(evt.summary), 32'h1);
    check("irq gated", 32'(evt.irq), 32'h0);
  endtask
  task automatic t_irq();
    logic [31:0] v;
    logic [31:0] w;
    wr(pcif_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check("irq", 32'(evt.irq), 32'h1);
    check("wake awake", 32'(evt.wake), 32'h0);
    u_pins.set_sleep(1'b1);
    repeat (2) @(posedge clk);
    check("wake", 32'(evt.wake), 32'h1);
    // Clear only the bits seen set, by read then masked write
    for (int p = 0; p < 4; p++) begin
      bus(32'(16 * p + 8), 1'b0, '0, v);
      bus(32'(16 * p + 8), 1'b0, '0, w);
      wr(32'(16 * p + 8), w & ~v);
    end
    repeat (3) @(posedge clk);
    check("irq cleared", 32'(evt), 32'h0);
    u_pins.set_pin(2, 3, 1'b1);
    repeat (4) @(posedge clk);
    check("wake by edge", 32'(evt.wake), 32'h1);
    rd_chk("ctrl in sleep", pcif_pkg::OFS_CTRL, 32'h0000_0007);
    u_pins.set_sleep(1'b0);
    rd_chk("c flags after sleep", 32'h0000_0028, 32'h0000_0008);
  endtask
  task automatic t_collide();
    wr(32'h0000_0024, 32'h0000_0008); wr(32'h0000_0028, 32'h0000_0000);
    // Clear write lands on the very edge at which the falling edge sets the flag
    fork
      u_pins.set_pin(2, 3, 1'b0);
      begin
        @(posedge clk);
        wr(32'h0000_0028, 32'h0000_0000);
      end
    join
    repeat (3) @(posedge clk);
    rd_chk("set wins", 32'h0000_0028, 32'h0000_0008);
    wr(32'h0000_0028, 32'h0000_0000);
    rd_chk("flag cleared", 32'h0000_0028, '0);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence after a four cycle reset
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset(); t_widths(); t_edges(); t_irq(); t_collide();
    wrap_up();
  end
  // Watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule
